// ===== pg_consts.svh
// Register indexes, field positions and reset values of the pulse block
`ifndef PG_CONSTS_SVH
`define PG_CONSTS_SVH

`define PG_CHANNELS 8
`define PG_PRE_WIDTH 7
`define PG_IDX_WIDTH 30

`define PG_IDX_ENABLE 30'h1b0000
`define PG_IDX_POLARITY 30'h1b0001
`define PG_IDX_CLK_CHOICE 30'h1b0002
`define PG_IDX_PRESCALE 30'h1b0003
`define PG_IDX_CENTER 30'h1b0004
`define PG_IDX_CONTROL 30'h1b0005
`define PG_IDX_SCALE_A 30'h1b0008
`define PG_IDX_SCALE_B 30'h1b0009
`define PG_IDX_COUNTER 30'h1b000c
`define PG_IDX_PERIOD 30'h1b0014
`define PG_IDX_DUTY 30'h1b001c
`define PG_IDX_SHUTDOWN 30'h1b0024

`define PG_RESET_ZERO 8'h00
`define PG_RESET_PER_DTY 8'hff

`define PG_MASK_PRESCALE 8'h77
`define PG_MASK_CONTROL 8'hfc
`define PG_MASK_ALL 8'hff

`define PG_PCKA_LSB 0
`define PG_PCKB_LSB 4
`define PG_PAIR_0_1_CONCATENATE_BIT 4
`define PG_SEL_WORD 4'hf

`endif

// ===== pg_types_pkg.sv
// Shared types of the pulse block
package pg_types_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] sel_t;
    typedef logic [31:0] word_t;
    typedef enum logic {SRC_A, SRC_B} src_e;
endpackage

// ===== pg_channel.sv
// One pulse channel: counter, double buffers and waveform compare
`timescale 1ns/1ps
`include "pg_consts.svh"
module pg_channel
    import pg_types_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic enable,
    input wire logic polarity,
    input wire logic center,
    input wire pg_types_pkg::byte_t period,
    input wire pg_types_pkg::byte_t duty,
    input wire logic cnt_clr,
    output pg_types_pkg::byte_t count,
    output logic wave
);
    byte_t per_act;
    byte_t dty_act;
    logic run;
    logic down;
    logic left_end;
    logic center_turn;
    logic center_end;
    logic load;

    assign left_end = (per_act == 8'h00) || (count >= 8'(per_act - 8'h01));
    assign center_turn = !down && (count >= per_act);
    assign center_end = down && (count == 8'h00);
    // Buffers reload at period end, on a counter write or while stopped, never mid-waveform
    assign load = !run || cnt_clr || (tick && (center ? center_end : left_end)); // R03
    // Polarity is not buffered, so a change may stretch the current pulse
    assign wave = run && ((count < dty_act) ? polarity : !polarity); // R13 R14 R16

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            run <= 1'b0;
        else if (!enable)
            run <= 1'b0;
        else if (tick)
            run <= 1'b1; // R10
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            per_act <= `PG_RESET_PER_DTY;
            dty_act <= `PG_RESET_PER_DTY;
        end
        else if (load)
        begin
            per_act <= period; // R03
            dty_act <= duty;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count <= `PG_RESET_ZERO;
            down <= 1'b0;
        end
        else if (!run || cnt_clr)
        begin
            count <= 8'h00;
            down <= 1'b0;
        end
        else if (tick)
        begin
            if (!center)
                count <= left_end ? 8'h00 : 8'(count + 8'h01); // R04 R20
            else if (per_act == 8'h00)
                count <= 8'h00;
            else if (center_turn)
            begin
                down <= 1'b1; // R04
                count <= 8'(count - 8'h01);
            end
            else if (center_end)
            begin
                down <= 1'b0;
                count <= 8'h01;
            end
            else
                count <= down ? 8'(count - 8'h01) : 8'(count + 8'h01);
        end
    end

    a_enable_waits: assert property ( // R10
        @(posedge sys_clk) disable iff (rst)
        (!run && enable && !tick) |=> !run)
        else $error("channel started without a clock tick");

    a_buffer_hold: assert property ( // R03
        @(posedge sys_clk) disable iff (rst)
        (run && !cnt_clr && !tick && enable) |=> $stable(dty_act) && $stable(per_act))
        else $error("duty or period changed mid-waveform");

    a_count_steps: assert property ( // R20
        @(posedge sys_clk) disable iff (rst)
        (run && enable && !tick && !cnt_clr) |=> $stable(count))
        else $error("counter moved without a tick");

    a_low_start: assert property ( // R13
        @(posedge sys_clk) disable iff (rst)
        (run && !polarity && count == 8'h00 && dty_act != 8'h00) |-> !wave)
        else $error("low polarity did not start low");

    a_high_start: assert property ( // R14
        @(posedge sys_clk) disable iff (rst)
        (run && polarity && count >= dty_act) |-> !wave)
        else $error("high polarity did not fall at duty count");
endmodule

// ===== pulse_gen.sv
// Eight channel pulse generator with classic Wishbone register slave
//
// Overview of operation
// R01 - Eight channels in one contiguous register block
// R02 - Period and duty registers are one byte
// R03 - Period and duty reload only at boundaries
// R04 - Left or center aligned per channel
// R05 - Four clock sources: A, B, scaled A, B
// R06 - Unmapped addresses and undefined bits ignore writes
// R07 - Full word access ends in error
// R08 - Reset: period, duty 0xff, rest zero
// R09 - Enable bit n drives channel n
// R10 - Output starts at next source clock cycle
// R11 - Prescaler stops when no channel enabled
// R12 - Concatenated pair holds even output off
// R13 - Polarity 0: low first, high at duty
// R14 - Polarity 1: high first, low at duty
// R15 - Concatenated even polarity has no effect
// R16 - Polarity change acts at once, unsynchronised
// R17 - Software sets pin muxing beforehand
// R18 - Channels 0,1,4,5 on A; others B
// R19 - Software changes concatenation only when disabled
// R20 - Eight bit counter advances per tick
`timescale 1ns/1ps
`include "pg_consts.svh"
module pulse_gen
    import pg_types_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire pg_types_pkg::word_t adr_i,
    input wire pg_types_pkg::sel_t sel_i,
    input wire pg_types_pkg::word_t dat_i,
    output pg_types_pkg::word_t dat_o,
    output logic ack_o,
    output logic err_o,
    output logic [7:0] waveform_output_pin
);
    localparam int NCH = `PG_CHANNELS;

    byte_t channel_output_enable;
    byte_t channel_start_polarity;
    byte_t channel_clock_choice;
    byte_t prescale_clock_choice;
    byte_t center_align_select;
    byte_t block_control;
    byte_t scale_a_divider;
    byte_t scale_b_divider;
    byte_t emergency_shutdown;
    byte_t channel_period_array [NCH];
    byte_t channel_duty_array [NCH];
    byte_t channel_counter_array [NCH];

    logic [`PG_IDX_WIDTH-1:0] idx;
    logic req;
    logic word_req;
    logic wr_en;
    logic rd_en;
    byte_t wbyte;
    byte_t rd_byte;

    logic hit_enable;
    logic hit_polarity;
    logic hit_clk_choice;
    logic hit_prescale;
    logic hit_center;
    logic hit_control;
    logic hit_scale_a;
    logic hit_scale_b;
    logic hit_shutdown;
    logic hit_counter;
    logic hit_period;
    logic hit_duty;
    logic hit_any;
    logic [2:0] arr_sel;

    logic any_enabled;
    logic [`PG_PRE_WIDTH-1:0] pre_cnt;
    logic [1:0] base_tick;
    logic [1:0] scaled_tick;
    logic [NCH-1:0] chan_tick;
    logic [NCH-1:0] hold_mask;
    logic [NCH-1:0] chan_enable;
    logic [NCH-1:0] chan_wave;
    logic [NCH-1:0] cnt_clr;
    logic [3:0] pair_concatenate_bit;

    // Bus decode: each printed index is one aligned word
    assign idx = adr_i[31:2];
    assign req = cyc_i && stb_i && !ack_o && !err_o;
    // Byte and halfword are fine; only the full word is refused
    assign word_req = req && (sel_i == `PG_SEL_WORD); // R07
    assign wr_en = req && !word_req && we_i && sel_i[0];
    assign rd_en = req && !word_req;
    assign wbyte = dat_i[7:0];

    assign hit_enable = (idx == `PG_IDX_ENABLE); // R01
    assign hit_polarity = (idx == `PG_IDX_POLARITY);
    assign hit_clk_choice = (idx == `PG_IDX_CLK_CHOICE);
    assign hit_prescale = (idx == `PG_IDX_PRESCALE);
    assign hit_center = (idx == `PG_IDX_CENTER);
    assign hit_control = (idx == `PG_IDX_CONTROL);
    assign hit_scale_a = (idx == `PG_IDX_SCALE_A);
    assign hit_scale_b = (idx == `PG_IDX_SCALE_B);
    assign hit_shutdown = (idx == `PG_IDX_SHUTDOWN);
    assign hit_counter = (idx >= `PG_IDX_COUNTER) && (idx < `PG_IDX_PERIOD);
    assign hit_period = (idx >= `PG_IDX_PERIOD) && (idx < `PG_IDX_DUTY);
    assign hit_duty = (idx >= `PG_IDX_DUTY) && (idx < `PG_IDX_SHUTDOWN);
    assign hit_any = hit_enable || hit_polarity || hit_clk_choice || hit_prescale
        || hit_center || hit_control || hit_scale_a || hit_scale_b || hit_shutdown
        || hit_counter || hit_period || hit_duty;
    // Arrays are eight entries on an index four past an eight-aligned one
    assign arr_sel = idx[2:0] ^ 3'h4;

    always_comb
    begin
        rd_byte = 8'h00;
        if (hit_enable)
            rd_byte = channel_output_enable;
        else if (hit_polarity)
            rd_byte = channel_start_polarity;
        else if (hit_clk_choice)
            rd_byte = channel_clock_choice;
        else if (hit_prescale)
            rd_byte = prescale_clock_choice;
        else if (hit_center)
            rd_byte = center_align_select;
        else if (hit_control)
            rd_byte = block_control;
        else if (hit_scale_a)
            rd_byte = scale_a_divider;
        else if (hit_scale_b)
            rd_byte = scale_b_divider;
        else if (hit_shutdown)
            rd_byte = emergency_shutdown;
        else if (hit_counter)
            rd_byte = channel_counter_array[arr_sel];
        else if (hit_period)
            rd_byte = channel_period_array[arr_sel];
        else if (hit_duty)
            rd_byte = channel_duty_array[arr_sel];
    end

    // Answer one cycle after the request; unmapped reads return zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= rd_en;
            err_o <= word_req; // R07
            if (rd_en)
                dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // Scalar registers; writes elsewhere fall through untouched
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            channel_output_enable <= `PG_RESET_ZERO; // R08
            channel_start_polarity <= `PG_RESET_ZERO;
            channel_clock_choice <= `PG_RESET_ZERO;
            prescale_clock_choice <= `PG_RESET_ZERO;
            center_align_select <= `PG_RESET_ZERO;
            block_control <= `PG_RESET_ZERO;
            scale_a_divider <= `PG_RESET_ZERO;
            scale_b_divider <= `PG_RESET_ZERO;
            emergency_shutdown <= `PG_RESET_ZERO;
        end
        else if (wr_en)
        begin
            if (hit_enable)
                channel_output_enable <= wbyte; // R09
            if (hit_polarity)
                channel_start_polarity <= wbyte;
            if (hit_clk_choice)
                channel_clock_choice <= wbyte;
            if (hit_prescale)
                prescale_clock_choice <= wbyte & `PG_MASK_PRESCALE; // R06
            if (hit_center)
                center_align_select <= wbyte;
            if (hit_control)
                block_control <= wbyte & `PG_MASK_CONTROL; // R06
            if (hit_scale_a)
                scale_a_divider <= wbyte;
            if (hit_scale_b)
                scale_b_divider <= wbyte;
            if (hit_shutdown)
                emergency_shutdown <= wbyte & `PG_MASK_ALL;
        end
    end

    // Prescaler freezes, not clears, so a restart keeps its phase
    assign any_enabled = |channel_output_enable;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pre_cnt <= '0;
        else if (any_enabled)
            pre_cnt <= `PG_PRE_WIDTH'(pre_cnt + 1'b1); // R11
    end

    // Clock A and B, then their scaled versions dividing by twice the scale
    genvar s;
    generate
        for (s = 0; s < 2; s++)
        begin : g_src
            logic [2:0] pick;
            logic [`PG_PRE_WIDTH-1:0] mask;
            logic [8:0] sc_cnt;
            logic [8:0] sc_last;
            byte_t scale;

            assign pick = (s == SRC_A) ? prescale_clock_choice[`PG_PCKA_LSB +: 3]
                : prescale_clock_choice[`PG_PCKB_LSB +: 3];
            assign mask = `PG_PRE_WIDTH'(~({`PG_PRE_WIDTH{1'b1}} << pick));
            assign scale = (s == SRC_A) ? scale_a_divider : scale_b_divider;
            // A zero scale wraps to the longest division
            assign sc_last = 9'({scale, 1'b0} - 9'h001);
            assign base_tick[s] = any_enabled && ((pre_cnt & mask) == mask); // R05 R11
            assign scaled_tick[s] = base_tick[s] && (sc_cnt == sc_last); // R05

            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                    sc_cnt <= 9'h000;
                else if (base_tick[s])
                    sc_cnt <= (sc_cnt >= sc_last) ? 9'h000 : 9'(sc_cnt + 9'h001);
            end
        end
    endgenerate

    // Concatenation bits gate the even channel of each pair
    assign pair_concatenate_bit = block_control[`PG_PAIR_0_1_CONCATENATE_BIT +: 4];

    genvar i;
    generate
        for (i = 0; i < NCH; i++)
        begin : g_ch
            localparam int SRC = (i / 2) % 2;

            if (i % 2 == 0)
            begin : g_even
                assign hold_mask[i] = pair_concatenate_bit[i / 2]; // R12 R15
            end
            else
            begin : g_odd
                assign hold_mask[i] = 1'b0;
            end

            assign chan_tick[i] = channel_clock_choice[i] ? scaled_tick[SRC]
                : base_tick[SRC]; // R18
            assign chan_enable[i] = channel_output_enable[i] && !hold_mask[i]; // R09 R12
            assign cnt_clr[i] = wr_en && hit_counter && (arr_sel == 3'(i));

            // Period and duty are the software-side buffer stage
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    channel_period_array[i] <= `PG_RESET_PER_DTY; // R08
                    channel_duty_array[i] <= `PG_RESET_PER_DTY;
                end
                else if (wr_en && (arr_sel == 3'(i)))
                begin
                    if (hit_period)
                        channel_period_array[i] <= wbyte; // R02
                    if (hit_duty)
                        channel_duty_array[i] <= wbyte;
                end
            end

            pg_channel u_chan (
                .sys_clk(sys_clk),
                .rst(rst),
                .tick(chan_tick[i]),
                .enable(chan_enable[i]),
                .polarity(channel_start_polarity[i]),
                .center(center_align_select[i]),
                .period(channel_period_array[i]),
                .duty(channel_duty_array[i]),
                .cnt_clr(cnt_clr[i]),
                .count(channel_counter_array[i]),
                .wave(chan_wave[i])
            );
        end
    endgenerate

    // Pins registered; held channels stay low
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            waveform_output_pin <= 8'h00;
        else
            waveform_output_pin <= chan_wave & ~hold_mask; // R12
    end

    a_word_refused: assert property ( // R07
        @(posedge sys_clk) disable iff (rst)
        (cyc_i && stb_i && !ack_o && !err_o && sel_i == 4'hf) |=> (err_o && !ack_o))
        else $error("word access was not refused");

    a_unmapped_quiet: assert property ( // R06
        @(posedge sys_clk) disable iff (rst)
        (req && we_i && !hit_any)
        |=> $stable({channel_output_enable, channel_start_polarity, block_control,
            center_align_select, channel_clock_choice, prescale_clock_choice}))
        else $error("unmapped write changed state");

    a_reserved_bits: assert property ( // R06
        @(posedge sys_clk) disable iff (rst)
        1'b1 |-> ((prescale_clock_choice & 8'h88) == 8'h00)
            && ((block_control & 8'h03) == 8'h00))
        else $error("reserved bit became set");

    a_prescale_idle: assert property ( // R11
        @(posedge sys_clk) disable iff (rst)
        (channel_output_enable == 8'h00) |=> $stable(pre_cnt))
        else $error("prescaler ran with all channels off");

    a_concat_hold: assert property ( // R12
        @(posedge sys_clk) disable iff (rst)
        (block_control[4] && $past(block_control[4])) |-> !waveform_output_pin[0])
        else $error("even channel driven while concatenated");

    a_reset_values: assert property ( // R08
        @(posedge sys_clk) disable iff (rst)
        $past(rst) |-> (channel_period_array[3] == 8'hff)
            && (channel_duty_array[5] == 8'hff) && (channel_output_enable == 8'h00))
        else $error("reset values wrong");

    a_ack_single: assert property (
        @(posedge sys_clk) disable iff (rst)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    a_clock_pick: assert property ( // R18
        @(posedge sys_clk) disable iff (rst)
        (!channel_clock_choice[2] && base_tick[1]) |-> chan_tick[2])
        else $error("channel two not on clock B");

    a_disabled_low: assert property ( // R09
        @(posedge sys_clk) disable iff (rst)
        (!channel_output_enable[1] && $past(!channel_output_enable[1]))
        |=> !waveform_output_pin[1])
        else $error("disabled channel drove its pin");
endmodule

// ===== pin_load_filter.sv
// Load model on the pulse outputs: counts high samples per pin
`timescale 1ns/1ps
module pin_load_filter
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic [7:0] pins,
    output logic [15:0] high_count [8]
);
    // Counting stands in for an RC filter: exact, and blind to phase
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 8; i++)
                high_count[i] <= 16'h0000;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
                high_count[i] <= clear ? 16'h0000 : 16'(high_count[i] + {15'h0000, pins[i]});
        end
    end
endmodule

// ===== tb_top.sv
// Self-checking bench for the eight channel pulse generator
`timescale 1ns/1ps
`include "pg_consts.svh"
module tb_top;
    import pg_types_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    word_t adr_i = 32'h00000000;
    sel_t sel_i = 4'h0;
    word_t dat_i = 32'h00000000;
    word_t dat_o;
    logic ack_o;
    logic err_o;
    logic filt_clr = 1'b0;
    logic [7:0] waveform_output_pin;
    logic [15:0] high_count [8];
    int miscompares = 0;
    int compares = 0;
    byte_t rd;
    logic be;

    always #50 sys_clk = ~sys_clk;

    // Pins wired straight to the load, as after pin muxing is set
    pulse_gen dut_u (.sys_clk(sys_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .err_o(err_o), .waveform_output_pin(waveform_output_pin));
    pin_load_filter load_u (.sys_clk(sys_clk), .rst(rst), .clear(filt_clr),
        .pins(waveform_output_pin), .high_count(high_count));

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk_byte(input byte_t got, input byte_t exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t byte got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_level(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t high count got %0d exp %0d", $time, got, exp);
        end
    endtask

    // Held until ack or err is sampled; bounded so a dead slave ends the run
    task automatic bus(input logic w, input logic [29:0] idx, input byte_t d, input sel_t s);
        int n;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            miscompares++;
            $display("BAD t=%0t bus answer never came", $time);
            complete_run();
        end
        else
        begin
            rd = dat_o[7:0];
            be = err_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            we_i <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    task automatic wr(input logic [29:0] idx, input byte_t d);
        bus(1'b1, idx, d, 4'h1);
    endtask

    task automatic rd_chk(input logic [29:0] idx, input byte_t exp);
        bus(1'b0, idx, 8'h00, 4'h1);
        chk_byte(rd, exp);
    endtask

    // Forty samples; every period used below divides forty, save t_buffer's 200, measured only while its wave is flat
    task automatic measure(input int ch, input logic [15:0] exp);
        filt_clr <= 1'b1;
        @(posedge sys_clk);
        filt_clr <= 1'b0;
        repeat (41) @(posedge sys_clk);
        chk_level(high_count[ch], exp);
    endtask

    task automatic t_reset();
        logic [29:0] regs [9];
        regs = '{`PG_IDX_ENABLE, `PG_IDX_POLARITY, `PG_IDX_CLK_CHOICE, `PG_IDX_PRESCALE,
            `PG_IDX_CENTER, `PG_IDX_CONTROL, `PG_IDX_SCALE_A, `PG_IDX_SCALE_B, `PG_IDX_SHUTDOWN};
        chk_byte(waveform_output_pin, 8'h00);
        for (int i = 0; i < 9; i++)
            rd_chk(regs[i], 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            rd_chk(30'(`PG_IDX_COUNTER + i), 8'h00);
            rd_chk(30'(`PG_IDX_PERIOD + i), 8'hff);
            rd_chk(30'(`PG_IDX_DUTY + i), 8'hff);
        end
    endtask

    task automatic t_reserved();
        wr(`PG_IDX_PRESCALE, 8'hff);
        rd_chk(`PG_IDX_PRESCALE, 8'h77);
        wr(`PG_IDX_CONTROL, 8'hff);
        rd_chk(`PG_IDX_CONTROL, 8'hfc);
        wr(30'h1b0006, 8'hff);
        rd_chk(30'h1b0006, 8'h00);
        rd_chk(`PG_IDX_ENABLE, 8'h00);
        wr(`PG_IDX_PRESCALE, 8'h00);
        wr(`PG_IDX_CONTROL, 8'h00);
        bus(1'b1, `PG_IDX_PERIOD, 8'h12, 4'hf);
        chk_byte({7'h00, be}, 8'h01);
        rd_chk(`PG_IDX_PERIOD, 8'hff);
        chk_byte(dat_o[31:24] | dat_o[23:16] | dat_o[15:8], 8'h00);
    endtask

    task automatic t_polarity();
        wr(`PG_IDX_PERIOD, 8'h04);
        wr(`PG_IDX_DUTY, 8'h01);
        wr(`PG_IDX_ENABLE, 8'h01);
        measure(0, 16'd30);
        chk_byte({waveform_output_pin[7:1], 1'b0}, 8'h00);
        wr(`PG_IDX_POLARITY, 8'h01);
        measure(0, 16'd10);
        wr(`PG_IDX_ENABLE, 8'h00);
        measure(0, 16'd0);
        wr(`PG_IDX_CENTER, 8'h01);
        wr(`PG_IDX_POLARITY, 8'h00);
        wr(`PG_IDX_ENABLE, 8'h01);
        measure(0, 16'd35);
        wr(`PG_IDX_ENABLE, 8'h00);
        wr(`PG_IDX_CENTER, 8'h00);
    endtask

    // Clock A crawls at /128, so only clock B can give a full-rate waveform
    task automatic t_clock_b();
        wr(`PG_IDX_PRESCALE, 8'h07);
        wr(30'(`PG_IDX_PERIOD + 2), 8'h04);
        wr(30'(`PG_IDX_DUTY + 2), 8'h01);
        wr(`PG_IDX_POLARITY, 8'h04);
        wr(`PG_IDX_ENABLE, 8'h04);
        measure(2, 16'd10);
        wr(`PG_IDX_ENABLE, 8'h00);
        wr(`PG_IDX_POLARITY, 8'h00);
        wr(`PG_IDX_PRESCALE, 8'h00);
    endtask

    task automatic t_buffer();
        wr(30'(`PG_IDX_PERIOD + 1), 8'hc8);
        wr(30'(`PG_IDX_DUTY + 1), 8'h64);
        wr(`PG_IDX_ENABLE, 8'h02);
        wr(30'(`PG_IDX_DUTY + 1), 8'h00);
        measure(1, 16'd0);
        repeat (200) @(posedge sys_clk);
        measure(1, 16'd40);
        wr(`PG_IDX_ENABLE, 8'h00);
    endtask

    task automatic t_concat();
        wr(30'(`PG_IDX_PERIOD + 1), 8'h04);
        wr(30'(`PG_IDX_DUTY + 1), 8'h01);
        wr(`PG_IDX_CONTROL, 8'h10);
        wr(`PG_IDX_POLARITY, 8'h01);
        wr(`PG_IDX_ENABLE, 8'h03);
        measure(0, 16'd0);
        measure(1, 16'd30);
        wr(`PG_IDX_ENABLE, 8'h00);
        wr(`PG_IDX_CONTROL, 8'h00);
    endtask

    // Scale 20 divides by 40: a 400 cycle gap holds ten ticks in any phase
    task automatic t_scaled();
        byte_t first_count;
        wr(`PG_IDX_SCALE_A, 8'h14);
        wr(`PG_IDX_CLK_CHOICE, 8'h10);
        wr(`PG_IDX_ENABLE, 8'h10);
        repeat (80) @(posedge sys_clk);
        bus(1'b0, 30'(`PG_IDX_COUNTER + 4), 8'h00, 4'h1);
        first_count = rd;
        repeat (397) @(posedge sys_clk);
        bus(1'b0, 30'(`PG_IDX_COUNTER + 4), 8'h00, 4'h1);
        chk_byte(8'(rd - first_count), 8'h0a);
        wr(`PG_IDX_ENABLE, 8'h00);
        wr(`PG_IDX_CLK_CHOICE, 8'h00);
        wr(`PG_IDX_SCALE_A, 8'h00);
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_reserved();
        t_polarity();
        t_clock_b();
        t_buffer();
        t_concat();
        t_scaled();
        complete_run();
    end
endmodule
